// ---- include/pt_pkg.sv ----
// Package of the periodic timer core: register map, field layouts, codes and timing counts.
// Assumes a 100 MHz system clock and an APB master with 32-bit data.
package pt_pkg;

  // ********************************************************************
  // Register map (byte addresses, one aligned word each)
  // ********************************************************************
  localparam logic [7:0] PT_ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] PT_ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] PT_ADDR_CNT_LO = 8'h08;
  localparam logic [7:0] PT_ADDR_CNT_HI = 8'h0C;
  localparam logic [7:0] PT_ADDR_CMPA_LO = 8'h10;
  localparam logic [7:0] PT_ADDR_CMPA_HI = 8'h14;
  localparam logic [7:0] PT_ADDR_CMPP_LO = 8'h18;
  localparam logic [7:0] PT_ADDR_CMPP_HI = 8'h1C;

  // ********************************************************************
  // Field layouts and reset values
  // ********************************************************************
  localparam int PT_CNT_W = 10;
  localparam logic [7:0] PT_CTRL0_RESET = 8'h00;
  localparam logic [7:0] PT_CTRL1_RESET = 8'h00;
  localparam logic [9:0] PT_CMP_RESET = 10'h000;
  localparam logic [9:0] PT_CNT_MAX = 10'h3FF;
  localparam logic [7:0] PT_CTRL0_MASK = 8'hF8;

  typedef enum logic [1:0] {
    PT_MODE_COMPARE = 2'b00,
    PT_MODE_CAPTURE = 2'b01,
    PT_MODE_PWM = 2'b10,
    PT_MODE_TIMER = 2'b11
  } pt_mode_t;

  typedef struct packed {
    logic count_pause;
    logic [2:0] clock_select;
    logic timer_on;
    logic [2:0] unused;
  } pt_ctrl0_t;

  typedef struct packed {
    pt_mode_t mode_select;
    logic [1:0] pin_function;
    logic output_initial_level;
    logic output_invert;
    logic capture_source_select;
    logic clear_on_a_match;
  } pt_ctrl1_t;

  // Clock select codes.
  localparam logic [2:0] PT_CK_SYS_DIV4 = 3'b000;
  localparam logic [2:0] PT_CK_SYS = 3'b001;
  localparam logic [2:0] PT_CK_HIGH_DIV16 = 3'b010;
  localparam logic [2:0] PT_CK_HIGH_DIV64 = 3'b011;
  localparam logic [2:0] PT_CK_SUB_A = 3'b100;
  localparam logic [2:0] PT_CK_SUB_B = 3'b101;
  localparam logic [2:0] PT_CK_EXT_RISE = 3'b110;
  localparam logic [2:0] PT_CK_EXT_FALL = 3'b111;

  // Pin function codes.
  localparam logic [1:0] PT_PF_0 = 2'b00;
  localparam logic [1:0] PT_PF_1 = 2'b01;
  localparam logic [1:0] PT_PF_2 = 2'b10;
  localparam logic [1:0] PT_PF_3 = 2'b11;

  // ********************************************************************
  // Timing counts
  // ********************************************************************
  localparam longint PT_SYS_HZ = 100000000;
  localparam longint PT_SUB_HZ = 32768;
  localparam logic [11:0] PT_SUB_DIV = 12'(PT_SYS_HZ / PT_SUB_HZ);
  localparam logic [5:0] PT_DIV4_MASK = 6'h03;
  localparam logic [5:0] PT_DIV16_MASK = 6'h0F;
  localparam logic [5:0] PT_DIV64_MASK = 6'h3F;

endpackage

// ---- sim/pt_timer_core_tb.sv ----
// Self-checking testbench of the periodic timer core: register access, clock selects,
// clear conditions, pin functions, capture triggers, pause and on/off handling.
// Assumes the designer's one-wait-state APB slave and pins synchronous to mclk.
`timescale 1ns/1ps
module pt_timer_core_tb;
  import pt_pkg::*;

  // ********************************************************************
  // Signals and design instance
  // ********************************************************************
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic capture_input_pin = 1'b0;
  logic external_clock_pin = 1'b0;
  logic timer_output_pin;
  logic timer_output_oe;
  logic match_a_flag;
  logic match_p_flag;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int a_seen = 0;
  int p_seen = 0;
  int a_last = 0;
  int p_last = 0;
  int a_period = 0;
  int p_period = 0;
  logic [31:0] rd;
  logic er;
  int n1;
  int n2;
  int base;
  logic [7:0] pctl [11] = '{8'h08, 8'h18, 8'h20, 8'h38, 8'h3C, 8'h24, 8'h88, 8'h98, 8'hA8,
    8'hB8, 8'hC4};
  logic [2:0] pexp [11] = '{3'b111, 3'b110, 3'b101, 3'b110, 3'b101, 3'b110, 3'b100, 3'b111,
    3'b110, 3'b110, 3'b000};
  logic [7:0] cctl [6] = '{8'h40, 8'h50, 8'h60, 8'h70, 8'h42, 8'h40};
  logic csel [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  int cexp [6] = '{2, 1, 3, 0, 2, 0};
  int fact [6] = '{4, 1, 16, 64, int'(PT_SUB_DIV), int'(PT_SUB_DIV)};

  pt_timer_core pt_timer_core_i (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_input_pin(capture_input_pin), .external_clock_pin(external_clock_pin),
    .timer_output_pin(timer_output_pin), .timer_output_oe(timer_output_oe),
    .match_a_flag(match_a_flag), .match_p_flag(match_p_flag)
  );

  initial begin
    forever #5 mclk = ~mclk;
  end

  // Event monitor: pulse counts and spacing in clock cycles.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (match_a_flag === 1'b1) begin
      a_seen <= a_seen + 1;
      a_period <= cyc - a_last;
      a_last <= cyc;
    end
    if (match_p_flag === 1'b1) begin
      p_seen <= p_seen + 1;
      p_period <= cyc - p_last;
      p_last <= cyc;
    end
  end

  // ********************************************************************
  // Tasks
  // ********************************************************************
  task automatic report_and_stop();
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request is held until pready is sampled high; data and error are taken at that edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      errors++;
      report_and_stop();
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    chk("read data", e, rd);
    chk("read error", 32'h0, {31'h0, er});
  endtask

  task automatic set_cmp(input logic [7:0] lo, input logic [9:0] v);
    wreg(lo, v[7:0]);
    wreg(lo + 8'h04, {6'h00, v[9:8]});
  endtask

  // A wait that runs out of cycles ends the run as a failure.
  task automatic wait_flag(input logic use_a, input int k);
    base = use_a ? a_seen : p_seen;
    for (int n = 0; n <= 30000; n++) begin
      @(posedge mclk);
      if ((use_a ? a_seen : p_seen) >= base + k) begin
        return;
      end
    end
    errors++;
    report_and_stop();
  endtask

  task automatic ext_pulses(input int n);
    repeat (n) begin
      external_clock_pin <= 1'b1;
      repeat (3) @(posedge mclk);
      external_clock_pin <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rchk(8'(i * 4), 32'h0);
    end
    wreg(PT_ADDR_CTRL0, 8'hFF);
    rchk(PT_ADDR_CTRL0, 32'h000000F8);
    wreg(PT_ADDR_CNT_LO, 8'h55);
    rchk(PT_ADDR_CNT_LO, 32'h0);
    wreg(PT_ADDR_CTRL0, 8'h00);
    wreg(PT_ADDR_CMPA_HI, 8'hFF);
    rchk(PT_ADDR_CMPA_HI, 32'h00000003);
    wreg(PT_ADDR_CMPP_LO, 8'hA5);
    rchk(PT_ADDR_CMPP_LO, 32'h000000A5);
    wreg(PT_ADDR_CTRL1, 8'hFF);
    rchk(PT_ADDR_CTRL1, 32'h000000FF);
    apb(1'b1, 8'h20, 8'h12);
    chk("unmapped write error", 32'h1, {31'h0, er});
    apb(1'b0, 8'h20, 8'h00);
    chk("unmapped read error", 32'h1, {31'h0, er});
    // Internal clock selects, measured as the spacing of P matches with P of 1.
    wreg(PT_ADDR_CTRL1, 8'h00);
    set_cmp(PT_ADDR_CMPA_LO, 10'h000);
    set_cmp(PT_ADDR_CMPP_LO, 10'h001);
    for (int c = 0; c < 6; c++) begin
      wreg(PT_ADDR_CTRL0, 8'h00);
      wreg(PT_ADDR_CTRL0, {1'b0, 3'(c), 1'b1, 3'b000});
      wait_flag(1'b0, 2);
      chk("p period", 32'(2 * fact[c]), 32'(p_period));
    end
    wreg(PT_ADDR_CTRL0, 8'h00);
    set_cmp(PT_ADDR_CMPP_LO, 10'h000);
    wreg(PT_ADDR_CTRL0, 8'h18);
    wait_flag(1'b0, 2);
    chk("overflow period", 32'd1024, 32'(p_period));
    // Clear on A: the top count bit takes part, and no P events are raised.
    wreg(PT_ADDR_CTRL0, 8'h00);
    wreg(PT_ADDR_CTRL1, 8'h01);
    set_cmp(PT_ADDR_CMPA_LO, 10'h203);
    set_cmp(PT_ADDR_CMPP_LO, 10'h002);
    wreg(PT_ADDR_CTRL0, 8'h18);
    n1 = p_seen;
    wait_flag(1'b1, 2);
    chk("a period", 32'd516, 32'(a_period));
    chk("p events", 32'(n1), 32'(p_seen));
    // Pin functions; each rise of timer_on restores the starting level.
    wreg(PT_ADDR_CTRL0, 8'h00);
    set_cmp(PT_ADDR_CMPA_LO, 10'h00A);
    set_cmp(PT_ADDR_CMPP_LO, 10'h014);
    for (int i = 0; i < 11; i++) begin
      wreg(PT_ADDR_CTRL1, pctl[i]);
      wreg(PT_ADDR_CTRL0, 8'h18);
      // PWM modes settle one cycle after the switch-on, so the third edge is used.
      repeat (3) @(posedge mclk);
      rd = {30'h0, timer_output_oe, timer_output_pin};
      chk("pin start", 32'(pexp[i][2:1]), rd);
      wait_flag(1'b1, 1);
      repeat (2) @(posedge mclk);
      chk("pin after", 32'(pexp[i][0]), 32'(timer_output_pin));
      wreg(PT_ADDR_CTRL0, 8'h00);
    end
    // Capture triggers and source select.
    set_cmp(PT_ADDR_CMPP_LO, 10'h000);
    for (int i = 0; i < 6; i++) begin
      set_cmp(PT_ADDR_CMPA_LO, 10'h000);
      wreg(PT_ADDR_CTRL1, cctl[i]);
      wreg(PT_ADDR_CTRL0, 8'h18);
      n1 = a_seen;
      external_clock_pin <= csel[i];
      capture_input_pin <= !csel[i];
      repeat (6) @(posedge mclk);
      n1 = a_seen - n1;
      n2 = a_seen;
      external_clock_pin <= 1'b0;
      capture_input_pin <= 1'b0;
      repeat (6) @(posedge mclk);
      n2 = a_seen - n2;
      chk("capture events", 32'(cexp[i]), 32'(n1 * 2 + n2));
      wreg(PT_ADDR_CTRL0, 8'h00);
    end
    // External clock edges with pause and power-down; counts are read back directly.
    wreg(PT_ADDR_CTRL1, 8'h00);
    for (int e = 0; e < 2; e++) begin
      wreg(PT_ADDR_CTRL0, 8'h00);
      wreg(PT_ADDR_CTRL0, e ? 8'h78 : 8'h68);
      ext_pulses(2);
      external_clock_pin <= 1'b1;
      repeat (3) @(posedge mclk);
      rchk(PT_ADDR_CNT_LO, e ? 32'd2 : 32'd3);
      wreg(PT_ADDR_CTRL0, e ? 8'hF8 : 8'hE8);
      external_clock_pin <= 1'b0;
      repeat (3) @(posedge mclk);
      ext_pulses(2);
      rchk(PT_ADDR_CNT_LO, e ? 32'd2 : 32'd3);
      wreg(PT_ADDR_CTRL0, e ? 8'h78 : 8'h68);
      ext_pulses(1);
      rchk(PT_ADDR_CNT_LO, e ? 32'd3 : 32'd4);
      wreg(PT_ADDR_CTRL0, e ? 8'h70 : 8'h60);
      ext_pulses(2);
      rchk(PT_ADDR_CNT_LO, e ? 32'd3 : 32'd4);
      wreg(PT_ADDR_CTRL0, e ? 8'h78 : 8'h68);
      rchk(PT_ADDR_CNT_LO, 32'h0);
    end
    report_and_stop();
  end
endmodule

// ---- src/pt_timer_core.sv ----
// Periodic timer core: 10-bit counter, two comparators, mode and pin logic, APB slave.
// Assumes the high clock equals the system clock and that the pins are synchronous to mclk.
//
// Overview of operation
// - Ten-bit up-counter advanced by a software-chosen internal or external clock.
// - Two ten-bit comparators check the whole count against values A and P.
// - Software cannot write the count; software clears it only by raising timer_on.
// - Count clears on overflow or chosen match, pulsing a request flag except on overflow under clear on A.
// - Pause bit 7 of control 0 freezes the count; clearing resumes it.
// - Clock select picks sys/4, sys, high/16, high/64, sub, external rise or fall.
// - Clearing timer_on stops and powers down, keeping the count.
// - A rising timer_on clears the counter to zero before counting.
// - A rising timer_on returns the output to its initial level, or to the inactive level in PWM functions 0 to 2.
// - Mode field bits 7..6 selects compare, capture, PWM or pulse, timer.
// - Timer/counter mode drives the output pin low with its enable off.
// - Compare mode A match: no change, low, high or toggle.
// - PWM mode: force inactive, force active, PWM wave, single pulse.
// - Capture mode trigger: rising, falling, both edges or disabled.
// - Read-only count pair and two read/write compare pairs.
// - Control 0 bits 2..0 read as zero.
// - Capture source select: 0 capture input pin, 1 external clock pin.
// - Clear on A match or overflow when set in compare or timer mode; otherwise P match, overflow when P is zero.
// - Initial level sets compare starting level and PWM active level.
// - Output invert flips the pin when set, not in timer mode.
`timescale 1ns/1ps
module pt_timer_core
  import pt_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer pins
  input wire logic capture_input_pin,
  input wire logic external_clock_pin,
  output logic timer_output_pin,
  output logic timer_output_oe,
  // Event pulses
  output logic match_a_flag,
  output logic match_p_flag
);

  // ********************************************************************
  // Registers
  // ********************************************************************
  pt_ctrl0_t ctrl0_reg;
  pt_ctrl1_t ctrl1_reg;
  logic [9:0] cnt_reg;
  logic [9:0] cnt_next;
  logic [9:0] cmpa_reg;
  logic [9:0] cmpp_reg;
  logic on_prev_reg;
  logic on_rise;
  logic cap_in_reg;
  logic cap_prev_reg;
  logic ext_in_reg;
  logic ext_prev_reg;
  logic [5:0] pre_reg;
  logic [11:0] sub_reg;
  logic sub_tick;
  logic tick;
  logic count_en;
  logic a_hit;
  logic p_hit;
  logic wrap;
  logic clr_hit;
  logic cap_event;
  logic pulse_end;
  logic level_reg;
  logic level_next;
  logic wr_en;
  logic rd_en;
  logic [7:0] rd_byte;
  logic addr_ok;

  // ********************************************************************
  // APB slave
  // ********************************************************************
  // One wait state keeps read data coming from a flip-flop.
  assign wr_en = psel && penable && pready && pwrite;
  assign rd_en = psel && penable && !pready;

  always_comb begin
    addr_ok = 1'b1;
    rd_byte = 8'h00;
    unique case (paddr)
      PT_ADDR_CTRL0: rd_byte = ctrl0_reg & PT_CTRL0_MASK;
      PT_ADDR_CTRL1: rd_byte = ctrl1_reg;
      PT_ADDR_CNT_LO: rd_byte = cnt_reg[7:0];
      PT_ADDR_CNT_HI: rd_byte = {6'h00, cnt_reg[9:8]};
      PT_ADDR_CMPA_LO: rd_byte = cmpa_reg[7:0];
      PT_ADDR_CMPA_HI: rd_byte = {6'h00, cmpa_reg[9:8]};
      PT_ADDR_CMPP_LO: rd_byte = cmpp_reg[7:0];
      PT_ADDR_CMPP_HI: rd_byte = {6'h00, cmpp_reg[9:8]};
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= rd_en;
      pslverr <= rd_en && !addr_ok;
      if (rd_en && !pwrite) begin
        prdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Control 0 also loses timer_on when a single pulse ends.
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl0_reg <= PT_CTRL0_RESET;
    end else if (wr_en && paddr == PT_ADDR_CTRL0) begin
      ctrl0_reg <= pwdata[7:0] & PT_CTRL0_MASK;
    end else if (pulse_end) begin
      ctrl0_reg.timer_on <= 1'b0;
    end
  end

  // Software is expected to stop the timer before changing mode bits.
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl1_reg <= PT_CTRL1_RESET;
    end else if (wr_en && paddr == PT_ADDR_CTRL1) begin
      ctrl1_reg <= pwdata[7:0];
    end
  end

  // A capture overwrites compare A; it wins over a write in the same cycle.
  always_ff @(posedge mclk) begin
    if (rst) begin
      cmpa_reg <= PT_CMP_RESET;
      cmpp_reg <= PT_CMP_RESET;
    end else begin
      if (cap_event) begin
        cmpa_reg <= cnt_reg;
      end else if (wr_en && paddr == PT_ADDR_CMPA_LO) begin
        cmpa_reg[7:0] <= pwdata[7:0];
      end else if (wr_en && paddr == PT_ADDR_CMPA_HI) begin
        cmpa_reg[9:8] <= pwdata[1:0];
      end
      if (wr_en && paddr == PT_ADDR_CMPP_LO) begin
        cmpp_reg[7:0] <= pwdata[7:0];
      end else if (wr_en && paddr == PT_ADDR_CMPP_HI) begin
        cmpp_reg[9:8] <= pwdata[1:0];
      end
    end
  end

  // ********************************************************************
  // Pins and clock sources
  // ********************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      cap_in_reg <= 1'b0;
      cap_prev_reg <= 1'b0;
      ext_in_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      cap_in_reg <= capture_input_pin;
      cap_prev_reg <= cap_in_reg;
      ext_in_reg <= external_clock_pin;
      ext_prev_reg <= ext_in_reg;
    end
  end

  // Prescalers run free, so a new selection takes effect within one period.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pre_reg <= 6'h00;
      sub_reg <= 12'h000;
    end else begin
      pre_reg <= pre_reg + 6'h01;
      sub_reg <= sub_tick ? 12'h000 : sub_reg + 12'h001;
    end
  end
  assign sub_tick = (sub_reg == PT_SUB_DIV - 12'h001);

  always_comb begin
    unique case (ctrl0_reg.clock_select)
      PT_CK_SYS_DIV4: tick = (pre_reg & PT_DIV4_MASK) == PT_DIV4_MASK;
      PT_CK_SYS: tick = 1'b1;
      PT_CK_HIGH_DIV16: tick = (pre_reg & PT_DIV16_MASK) == PT_DIV16_MASK;
      PT_CK_HIGH_DIV64: tick = pre_reg == PT_DIV64_MASK;
      PT_CK_SUB_A, PT_CK_SUB_B: tick = sub_tick;
      PT_CK_EXT_RISE: tick = ext_in_reg && !ext_prev_reg;
      PT_CK_EXT_FALL: tick = !ext_in_reg && ext_prev_reg;
    endcase
  end

  // ********************************************************************
  // Counter and comparators
  // ********************************************************************
  assign on_rise = ctrl0_reg.timer_on && !on_prev_reg;
  assign count_en = ctrl0_reg.timer_on && !ctrl0_reg.count_pause && tick;
  assign a_hit = count_en && cnt_reg == cmpa_reg && cmpa_reg != PT_CMP_RESET;
  assign p_hit = count_en && cnt_reg == (cmpp_reg == PT_CMP_RESET ? PT_CNT_MAX : cmpp_reg);
  assign wrap = count_en && cnt_reg == PT_CNT_MAX;
  assign pulse_end = a_hit && ctrl1_reg.mode_select == PT_MODE_PWM &&
    ctrl1_reg.pin_function == PT_PF_3;

  always_comb begin
    if (ctrl1_reg.clear_on_a_match && ctrl1_reg.mode_select != PT_MODE_PWM &&
        ctrl1_reg.mode_select != PT_MODE_CAPTURE) begin
      clr_hit = a_hit || wrap;
    end else begin
      clr_hit = p_hit;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      on_prev_reg <= 1'b0;
    end else begin
      on_prev_reg <= ctrl0_reg.timer_on;
    end
  end

  // There is deliberately no software write path into the count.
  always_comb begin
    cnt_next = cnt_reg;
    if (on_rise) begin
      cnt_next = 10'h000;
    end else if (count_en) begin
      cnt_next = clr_hit ? 10'h000 : cnt_reg + 10'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_reg <= 10'h000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // ********************************************************************
  // Capture and event flags
  // ********************************************************************
  always_comb begin
    logic rise;
    logic fall;
    rise = ctrl1_reg.capture_source_select ? (ext_in_reg && !ext_prev_reg) :
      (cap_in_reg && !cap_prev_reg);
    fall = ctrl1_reg.capture_source_select ? (!ext_in_reg && ext_prev_reg) :
      (!cap_in_reg && cap_prev_reg);
    cap_event = 1'b0;
    if (ctrl1_reg.mode_select == PT_MODE_CAPTURE && ctrl0_reg.timer_on) begin
      unique case (ctrl1_reg.pin_function)
        PT_PF_0: cap_event = rise;
        PT_PF_1: cap_event = fall;
        PT_PF_2: cap_event = rise || fall;
        PT_PF_3: cap_event = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      match_a_flag <= 1'b0;
      match_p_flag <= 1'b0;
    end else begin
      match_a_flag <= ctrl1_reg.mode_select == PT_MODE_CAPTURE ? cap_event : a_hit;
      match_p_flag <= p_hit && !(ctrl1_reg.clear_on_a_match &&
        (ctrl1_reg.mode_select == PT_MODE_COMPARE || ctrl1_reg.mode_select == PT_MODE_TIMER));
    end
  end

  // ********************************************************************
  // Output pin
  // ********************************************************************
  always_comb begin
    logic act;
    act = ctrl1_reg.output_initial_level;
    level_next = level_reg;
    if (on_rise) begin
      level_next = (ctrl1_reg.mode_select == PT_MODE_PWM && ctrl1_reg.pin_function != PT_PF_3) ?
        ~act : act;
    end else begin
      unique case (ctrl1_reg.mode_select)
        PT_MODE_COMPARE: begin
          if (a_hit) begin
            unique case (ctrl1_reg.pin_function)
              PT_PF_0: level_next = level_reg;
              PT_PF_1: level_next = 1'b0;
              PT_PF_2: level_next = 1'b1;
              PT_PF_3: level_next = ~level_reg;
            endcase
          end
        end
        PT_MODE_PWM: begin
          unique case (ctrl1_reg.pin_function)
            PT_PF_0: level_next = ~act;
            PT_PF_1: level_next = act;
            PT_PF_2: level_next = (cnt_next < cmpa_reg) ? act : ~act;
            PT_PF_3: level_next = pulse_end ? ~act : level_reg;
          endcase
        end
        PT_MODE_CAPTURE, PT_MODE_TIMER: level_next = level_reg;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      level_reg <= 1'b0;
      timer_output_pin <= 1'b0;
      timer_output_oe <= 1'b0;
    end else begin
      level_reg <= level_next;
      timer_output_oe <= ctrl1_reg.mode_select == PT_MODE_COMPARE ||
        ctrl1_reg.mode_select == PT_MODE_PWM;
      if (ctrl1_reg.mode_select == PT_MODE_TIMER) begin
        timer_output_pin <= 1'b0;
      end else begin
        timer_output_pin <= level_next ^ ctrl1_reg.output_invert;
      end
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  on_rise_clear_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(ctrl0_reg.timer_on) |=> cnt_reg == 10'h000)
    else $error("Count not cleared after timer switched on.");

  pause_hold_a: assert property (@(posedge mclk) disable iff (rst)
    ctrl0_reg.count_pause && !on_rise |=> $stable(cnt_reg))
    else $error("Count moved while paused.");

  off_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !ctrl0_reg.timer_on ##1 !ctrl0_reg.timer_on |-> $stable(cnt_reg))
    else $error("Count moved while switched off.");

  ctrl0_low_a: assert property (@(posedge mclk) disable iff (rst)
    pready && !pwrite && psel && paddr == PT_ADDR_CTRL0 |-> prdata[2:0] == 3'b000)
    else $error("Unimplemented control bits read as nonzero.");

  init_level_a: assert property (@(posedge mclk) disable iff (rst)
    on_rise && ctrl1_reg.mode_select == PT_MODE_COMPARE |=>
      timer_output_pin == ($past(ctrl1_reg.output_initial_level) ^
      $past(ctrl1_reg.output_invert)))
    else $error("Output not at initial level after switch on.");

  wrap_clear_a: assert property (@(posedge mclk) disable iff (rst)
    count_en && !on_rise && cnt_reg == PT_CNT_MAX |=> cnt_reg == 10'h000)
    else $error("Counter did not wrap to zero.");

  p_clear_a: assert property (@(posedge mclk) disable iff (rst)
    p_hit && !on_rise && !ctrl1_reg.clear_on_a_match |=>
      cnt_reg == 10'h000 ##0 match_p_flag)
    else $error("P match did not clear the count and flag it.");

  toggle_a: assert property (@(posedge mclk) disable iff (rst)
    a_hit && !on_rise && ctrl1_reg.mode_select == PT_MODE_COMPARE &&
      ctrl1_reg.pin_function == PT_PF_3 && $stable(ctrl1_reg.output_invert) |=>
      timer_output_pin != $past(timer_output_pin))
    else $error("Output did not toggle on A match.");

  pready_pulse_a: assert property (@(posedge mclk) disable iff (rst)
    pready |=> !pready)
    else $error("Bus answer held for more than one cycle.");

endmodule
